/* src/tfa_apdu_engine.sv */
// Command interpreter of a contactless tag: parses command frames, answers with status words.
// Assumes a byte stream from the RF front end on mclk and a byte-wide file memory port.
//
// Overview of operation
// - System select is CLA 00, A4, P1 00, P2 0C, two bytes E101, no Le.
// - System file becomes current only when select answers 90 00.
// - Missing system file gives 6A 82 with no data bytes.
// - Read is B0 with two-byte offset in P1-P2 and length of at least 01.
// - Read succeeds only if offset plus length fits inside the selected file.
// - Successful read returns the fetched bytes followed by 90 00.
// - Forbidden read or update gives 69 82 and moves no data.
// - Update is D6, offset in P1-P2, count 01 to F6, then the data bytes.
// - Update answers status only: 90 00 on success, 65 81 on memory failure.
// - Slow update requests a waiting-time extension before replying.
// - Verify with no data: 90 00 if no password needed, else 63 00.
// - Verify with sixteen data bytes compares against password chosen by P1-P2.
// - Matching password answers 90 00 while tries remain; with none left it answers 69 84.
// - Verify checks the access condition of the last selected NDEF file.
// - A good password grants its access type over the whole NDEF file.
// - Three password tries per session; wrong one answers 63 CX, X tries left.
// - Verify gives 69 84 without NDEF selection or with FF/FE locks.
// - Verify with a bad data length gives 6A 80.
// - Retry nibble in the wrong-password status is only 0, 1 or 2.
// - Unsupported P1 or P2 values give 6A 86.
`timescale 1ns/100ps
module tfa_apdu_engine #(
   parameter int FIFO_DEPTH = tfa_pkg::RSP_FIFO_DEPTH,
   parameter int WTX_LIMIT = tfa_pkg::WTX_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sessionStart,
   input wire logic cmdValid,
   input wire logic [7:0] cmdData,
   input wire logic cmdLast,
   output logic cmdReady,
   output logic rspValid,
   output logic [7:0] rspData,
   output logic rspLast,
   input wire logic rspReady,
   output logic memReq,
   output logic memWe,
   output tfa_pkg::tfa_file_type memFile,
   output logic [15:0] memAddr,
   output logic [7:0] memWdata,
   input wire logic [7:0] memRdata,
   input wire logic memAck,
   input wire logic memFail,
   output logic wtxReq,
   input wire logic sysFilePresent,
   input wire logic ndefFilePresent,
   input wire logic [15:0] sysFileLen,
   input wire logic [15:0] ndefFileLen,
   input wire logic [7:0] ndefReadRight,
   input wire logic [7:0] ndefWriteRight,
   input wire logic [tfa_pkg::PWD_BITS-1:0] readPassword,
   input wire logic [tfa_pkg::PWD_BITS-1:0] writePassword,
   output logic [1:0] retriesLeft
);
   import tfa_pkg::*;

   localparam int WTX_W = $clog2(WTX_LIMIT + 1);

   typedef enum logic [2:0] {S_RX, S_WR, S_EXEC, S_RREQ, S_RPUSH, S_SW1, S_SW2} tfa_state_type;

   tfa_state_type state;
   logic [7:0] hdr_r [HDR_BYTES];
   logic [2:0] hdrCnt_r;
   logic [7:0] dataCnt_r;
   logic lastSeen_r;
   logic wrFail_r;
   logic [PWD_BITS-1:0] pwdBuf_r;
   tfa_file_type fileSel_r;
   tfa_file_type memFile_r;
   logic readGrant_r;
   logic writeGrant_r;
   logic [1:0] retries_r;
   logic [15:0] sw_r;
   logic [15:0] memAddr_r;
   logic [7:0] memWdata_r;
   logic [7:0] rdByte_r;
   logic [7:0] rdLeft_r;
   logic [WTX_W-1:0] wtxCnt_r;
   logic wtxReq_r;

   logic [7:0] insB;
   logic [7:0] p3;
   logic [15:0] offset;
   logic [15:0] fileLen;
   logic [15:0] fid;
   logic isSelect;
   logic isRead;
   logic isUpdate;
   logic isVerify;
   logic cmdAccept;
   logic dataPhase;
   logic pwdSelWr;
   logic [7:0] selRight;
   logic pwdMatch;
   logic [15:0] updPreSw;
   logic [15:0] exSw;
   logic fifoInValid;
   logic fifoInReady;
   logic [7:0] fifoInByte;
   logic frameDone;

   // Status for an access given the current file and grants
   function automatic logic [15:0] accessSw(input tfa_file_type f, input logic wr);
      logic [7:0] right;
      logic grant;
      right = wr ? ndefWriteRight : ndefReadRight;
      grant = wr ? writeGrant_r : readGrant_r;
      if (f == FILE_NONE) begin
         accessSw = SW_NOT_FOUND;
      end else if (f == FILE_SYS) begin
         accessSw = wr ? SW_SECURITY : SW_OK;
      end else if (right == ACC_OPEN || (right == ACC_PWD && grant)) begin
         accessSw = SW_OK;
      end else begin
         accessSw = SW_SECURITY;
      end
   endfunction

   function automatic logic fitsFile(input logic [15:0] off, input logic [7:0] n, input logic [15:0] len);
      fitsFile = ({1'b0, off} + {9'h000, n}) <= {1'b0, len};
   endfunction

   assign insB = hdr_r[HDR_INS];
   assign p3 = hdr_r[HDR_P3];
   assign offset = {hdr_r[HDR_P1], hdr_r[HDR_P2]};
   assign fileLen = (fileSel_r == FILE_SYS) ? sysFileLen : ndefFileLen;
   assign fid = pwdBuf_r[FID_BITS-1:0];
   assign isSelect = (insB == INS_SELECT);
   assign isRead = (insB == INS_READ);
   assign isUpdate = (insB == INS_UPDATE);
   assign isVerify = (insB == INS_VERIFY);
   assign cmdReady = (state == S_RX);
   assign cmdAccept = cmdReady && cmdValid;
   assign dataPhase = (hdrCnt_r == HDR_CNT_FULL);
   assign pwdSelWr = (offset == PWD_SEL_WRITE);
   assign selRight = pwdSelWr ? ndefWriteRight : ndefReadRight;
   assign frameDone = (state == S_SW2) && fifoInReady;

   tfa_pwd_match #(
      .BYTES(PWD_BYTES)
   ) u_match (
      .rxPwd(pwdBuf_r),
      .refPwd(pwdSelWr ? writePassword : readPassword),
      .match(pwdMatch)
   );

   // Update checks made before the first data byte, so no byte lands outside rights or file
   always_comb begin
      updPreSw = accessSw(fileSel_r, 1'b1);
      if (updPreSw == SW_OK) begin
         if (p3 < LEN_MIN || p3 > LC_MAX_UPD) begin
            updPreSw = SW_WRONG_LEN;
         end else if (!fitsFile(offset, p3, fileLen)) begin
            updPreSw = SW_OVERFLOW;
         end
      end
   end

   always_comb begin
      exSw = SW_OK;
      if (hdrCnt_r < HDR_CNT_MIN) begin
         exSw = SW_WRONG_LEN;
      end else if (hdr_r[HDR_CLA] != CLA_ISO) begin
         exSw = SW_BAD_CLA;
      end else begin
         unique case (insB)
            INS_SELECT: begin
               if (hdr_r[HDR_P1] != SEL_P1 || hdr_r[HDR_P2] != SEL_P2) begin
                  exSw = SW_BAD_P1P2;
               end else if (p3 != SEL_LC || dataCnt_r != SEL_LC) begin
                  exSw = SW_WRONG_LEN;
               end else if (fid == FID_SYSTEM && sysFilePresent) begin
                  exSw = SW_OK;
               end else if (fid == FID_NDEF && ndefFilePresent) begin
                  exSw = SW_OK;
               end else begin
                  exSw = SW_NOT_FOUND;
               end
            end
            INS_READ: begin
               exSw = accessSw(fileSel_r, 1'b0);
               if (exSw == SW_OK && (!dataPhase || p3 < LEN_MIN || dataCnt_r != LC_NONE)) begin
                  exSw = SW_WRONG_LEN;
               end else if (exSw == SW_OK && !fitsFile(offset, p3, fileLen)) begin
                  exSw = SW_WRONG_LEN;
               end
            end
            INS_UPDATE: begin
               exSw = updPreSw;
               if (exSw == SW_OK && dataCnt_r != p3) begin
                  exSw = SW_WRONG_LEN;
               end else if (exSw == SW_OK && wrFail_r) begin
                  exSw = SW_UPD_FAIL;
               end
            end
            INS_VERIFY: begin
               if (fileSel_r != FILE_NDEF || ndefWriteRight == ACC_LOCK_WR || ndefReadRight == ACC_LOCK_RD) begin
                  exSw = SW_REF_UNUSABLE;
               end else if (offset != PWD_SEL_READ && !pwdSelWr) begin
                  exSw = SW_BAD_P1P2;
               end else if (p3 == LC_NONE) begin
                  exSw = (selRight == ACC_OPEN) ? SW_OK : SW_PWD_REQ;
               end else if (p3 != LC_PWD || dataCnt_r != LC_PWD) begin
                  exSw = SW_BAD_DATA;
               end else if (retries_r == RETRY_NONE) begin
                  exSw = SW_REF_UNUSABLE;
               end else if (pwdMatch) begin
                  exSw = SW_OK;
               end else begin
                  exSw = {SW_PWD_BAD_HI, 2'h0, retries_r - RETRY_STEP};
               end
            end
            default: begin
               exSw = SW_BAD_INS;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= S_RX;
      end else begin
         unique case (state)
            S_RX: begin
               if (cmdValid) begin
                  if (dataPhase && isUpdate && updPreSw == SW_OK && dataCnt_r < p3) begin
                     state <= S_WR;
                  end else if (cmdLast) begin
                     state <= S_EXEC;
                  end
               end
            end
            S_WR: begin
               if (memAck) begin
                  state <= lastSeen_r ? S_EXEC : S_RX;
               end
            end
            S_EXEC: begin
               state <= (isRead && exSw == SW_OK) ? S_RREQ : S_SW1;
            end
            S_RREQ: begin
               if (memAck) begin
                  state <= S_RPUSH;
               end
            end
            S_RPUSH: begin
               if (fifoInReady) begin
                  state <= (rdLeft_r == LEN_MIN) ? S_SW1 : S_RREQ;
               end
            end
            S_SW1: begin
               if (fifoInReady) begin
                  state <= S_SW2;
               end
            end
            S_SW2: begin
               if (fifoInReady) begin
                  state <= S_RX;
               end
            end
         endcase
      end
   end

   // Frame capture; header bytes clear at frame end so a 4-byte verify reads as no data
   always_ff @(posedge mclk) begin
      if (rst || frameDone) begin
         for (int i = 0; i < HDR_BYTES; i++) begin
            hdr_r[i] <= 8'h00;
         end
         hdrCnt_r <= 3'h0;
         dataCnt_r <= 8'h00;
         lastSeen_r <= 1'b0;
         pwdBuf_r <= '0;
      end else if (cmdAccept) begin
         lastSeen_r <= cmdLast;
         if (!dataPhase) begin
            hdr_r[hdrCnt_r] <= cmdData;
            hdrCnt_r <= hdrCnt_r + 3'h1;
         end else begin
            if (dataCnt_r != DATA_CNT_MAX) begin
               dataCnt_r <= dataCnt_r + 8'h01;
            end
            pwdBuf_r <= {pwdBuf_r[PWD_BITS-9:0], cmdData};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         memAddr_r <= 16'h0000;
         memWdata_r <= 8'h00;
         memFile_r <= FILE_NONE;
         rdLeft_r <= 8'h00;
         rdByte_r <= 8'h00;
      end else if (cmdAccept && dataPhase && isUpdate && updPreSw == SW_OK && dataCnt_r < p3) begin
         memAddr_r <= offset + {8'h00, dataCnt_r};
         memWdata_r <= cmdData;
         memFile_r <= fileSel_r;
      end else if (state == S_EXEC && isRead && exSw == SW_OK) begin
         memAddr_r <= offset;
         rdLeft_r <= p3;
         memFile_r <= fileSel_r;
      end else if (state == S_RREQ && memAck) begin
         rdByte_r <= memRdata;
      end else if (state == S_RPUSH && fifoInReady) begin
         memAddr_r <= memAddr_r + 16'h0001;
         rdLeft_r <= rdLeft_r - LEN_MIN;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || frameDone) begin
         wrFail_r <= 1'b0;
      end else if (state == S_WR && memAck && memFail) begin
         wrFail_r <= 1'b1;
      end
   end

   // Session state: selection, grants and retry budget
   always_ff @(posedge mclk) begin
      if (rst || sessionStart) begin
         fileSel_r <= FILE_NONE;
         readGrant_r <= 1'b0;
         writeGrant_r <= 1'b0;
         retries_r <= RETRY_INIT;
      end else if (state == S_EXEC) begin
         if (isSelect && exSw == SW_OK) begin
            fileSel_r <= (fid == FID_SYSTEM) ? FILE_SYS : FILE_NDEF;
         end
         if (isVerify && p3 == LC_PWD && exSw == SW_OK) begin
            readGrant_r <= readGrant_r || !pwdSelWr;
            writeGrant_r <= writeGrant_r || pwdSelWr;
         end
         if (isVerify && exSw[15:4] == SW_PWD_BAD_HI) begin
            retries_r <= retries_r - RETRY_STEP;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sw_r <= SW_OK;
      end else if (state == S_EXEC) begin
         sw_r <= exSw;
      end
   end

   // Extension request repeats each window while a write is still outstanding
   always_ff @(posedge mclk) begin
      if (rst || frameDone) begin
         wtxCnt_r <= '0;
         wtxReq_r <= 1'b0;
      end else begin
         wtxReq_r <= 1'b0;
         if (state == S_WR) begin
            if (wtxCnt_r == WTX_W'(WTX_LIMIT - 1)) begin
               wtxCnt_r <= '0;
               wtxReq_r <= 1'b1;
            end else begin
               wtxCnt_r <= wtxCnt_r + 1'b1;
            end
         end
      end
   end

   assign fifoInValid = (state == S_RPUSH) || (state == S_SW1) || (state == S_SW2);
   assign fifoInByte = (state == S_RPUSH) ? rdByte_r : ((state == S_SW1) ? sw_r[15:8] : sw_r[7:0]);

   tfa_byte_fifo #(
      .WIDTH(RSP_FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .inValid(fifoInValid),
      .inData({state == S_SW2, fifoInByte}),
      .inReady(fifoInReady),
      .outValid(rspValid),
      .outData({rspLast, rspData}),
      .outReady(rspReady)
   );

   assign memReq = (state == S_WR) || (state == S_RREQ);
   assign memWe = (state == S_WR);
   assign memFile = memFile_r;
   assign memAddr = memAddr_r;
   assign memWdata = memWdata_r;
   assign wtxReq = wtxReq_r;
   assign retriesLeft = retries_r;

   a_sys_select_marks: assert property (@(posedge mclk) disable iff (rst)
      (state == S_EXEC && isSelect && exSw == SW_OK && fid == FID_SYSTEM && !sessionStart)
      |=> fileSel_r == FILE_SYS) else $error("system file not current after good select");
   a_notfound_no_data: assert property (@(posedge mclk) disable iff (rst)
      (state == S_EXEC && exSw == SW_NOT_FOUND) |=> state == S_SW1 ##0 sw_r == SW_NOT_FOUND)
      else $error("not-found answer carried data");
   a_read_fits_file: assert property (@(posedge mclk) disable iff (rst)
      (state == S_EXEC && isRead && exSw == SW_OK) |-> fitsFile(offset, p3, fileLen))
      else $error("read accepted beyond file end");
   a_read_fetch_byte: assert property (@(posedge mclk) disable iff (rst)
      (state == S_RREQ && memAck) |=> state == S_RPUSH && rdByte_r == $past(memRdata))
      else $error("read byte not taken from memory");
   a_denied_no_data: assert property (@(posedge mclk) disable iff (rst)
      (state == S_EXEC && exSw == SW_SECURITY) |=> state == S_SW1 && !memReq)
      else $error("denied access moved data");
   a_update_fail_word: assert property (@(posedge mclk) disable iff (rst)
      (state == S_EXEC && isUpdate && exSw == SW_OK) |-> !wrFail_r && dataCnt_r == p3)
      else $error("update reported success after failed write");
   a_wtx_in_write: assert property (@(posedge mclk) disable iff (rst)
      wtxReq_r |-> $past(state == S_WR) ##1 !wtxReq_r) else $error("extension outside a write");
   a_retry_decrement: assert property (@(posedge mclk) disable iff (rst || sessionStart)
      (state == S_EXEC && isVerify && exSw[15:4] == SW_PWD_BAD_HI)
      |=> retries_r == $past(retries_r) - RETRY_STEP && sw_r[3:0] == {2'h0, retries_r})
      else $error("retry count not reported or consumed");
   a_retry_nibble: assert property (@(posedge mclk) disable iff (rst)
      (sw_r[15:4] == SW_PWD_BAD_HI) |-> sw_r[3:0] < {2'h0, RETRY_INIT}) else $error("retry nibble above two");
   a_verify_needs_ndef: assert property (@(posedge mclk) disable iff (rst)
      (state == S_EXEC && isVerify && hdrCnt_r >= HDR_CNT_MIN && hdr_r[HDR_CLA] == CLA_ISO
       && fileSel_r != FILE_NDEF) |-> exSw == SW_REF_UNUSABLE)
      else $error("verify answered without NDEF selection");
   a_session_clears: assert property (@(posedge mclk) disable iff (rst)
      sessionStart |=> retries_r == RETRY_INIT && !readGrant_r && !writeGrant_r && fileSel_r == FILE_NONE)
      else $error("session start left grants");
   a_grant_full_match: assert property (@(posedge mclk) disable iff (rst)
      (state == S_EXEC && isVerify && p3 == LC_PWD && exSw == SW_OK)
      |-> pwdBuf_r == (pwdSelWr ? writePassword : readPassword)) else $error("grant on partial match");
endmodule

/* src/tfa_pkg.sv */
// Constants, status words and shared types of the tag file-access command engine.
// Assumes a 100 MHz core clock; every consumer imports the whole package.
package tfa_pkg;
   localparam logic [7:0] CLA_ISO = 8'h00;
   localparam logic [7:0] INS_SELECT = 8'hA4;
   localparam logic [7:0] INS_READ = 8'hB0;
   localparam logic [7:0] INS_UPDATE = 8'hD6;
   localparam logic [7:0] INS_VERIFY = 8'h20;
   localparam logic [7:0] SEL_P1 = 8'h00;
   localparam logic [7:0] SEL_P2 = 8'h0C;
   localparam logic [7:0] SEL_LC = 8'h02;
   localparam logic [15:0] FID_SYSTEM = 16'hE101;
   localparam logic [15:0] FID_NDEF = 16'h0001;
   localparam int FID_BITS = 16;
   localparam logic [7:0] LEN_MIN = 8'h01;
   localparam logic [7:0] LC_MAX_UPD = 8'hF6;
   localparam logic [7:0] LC_NONE = 8'h00;
   localparam logic [7:0] LC_PWD = 8'h10;
   localparam logic [7:0] DATA_CNT_MAX = 8'hFF;
   localparam logic [7:0] ACC_OPEN = 8'h00;
   localparam logic [7:0] ACC_PWD = 8'h80;
   localparam logic [7:0] ACC_LOCK_RD = 8'hFE;
   localparam logic [7:0] ACC_LOCK_WR = 8'hFF;
   localparam logic [15:0] PWD_SEL_READ = 16'h0001;
   localparam logic [15:0] PWD_SEL_WRITE = 16'h0002;
   localparam logic [1:0] RETRY_INIT = 2'h3;
   localparam logic [1:0] RETRY_STEP = 2'h1;
   localparam logic [1:0] RETRY_NONE = 2'h0;
   localparam int PWD_BYTES = 16;
   localparam int PWD_BITS = 128;
   localparam int HDR_BYTES = 5;
   localparam logic [2:0] HDR_CNT_FULL = 3'h5;
   localparam logic [2:0] HDR_CNT_MIN = 3'h4;
   localparam int HDR_CLA = 0;
   localparam int HDR_INS = 1;
   localparam int HDR_P1 = 2;
   localparam int HDR_P2 = 3;
   localparam int HDR_P3 = 4;
   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [15:0] SW_PWD_REQ = 16'h6300;
   localparam logic [11:0] SW_PWD_BAD_HI = 12'h63C;
   localparam logic [15:0] SW_UPD_FAIL = 16'h6581;
   localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
   localparam logic [15:0] SW_SECURITY = 16'h6982;
   localparam logic [15:0] SW_REF_UNUSABLE = 16'h6984;
   localparam logic [15:0] SW_BAD_DATA = 16'h6A80;
   localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
   localparam logic [15:0] SW_OVERFLOW = 16'h6A84;
   localparam logic [15:0] SW_BAD_P1P2 = 16'h6A86;
   localparam logic [15:0] SW_BAD_INS = 16'h6D00;
   localparam logic [15:0] SW_BAD_CLA = 16'h6E00;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WTX_WINDOW_NS = 20000;
   localparam int WTX_CYCLES = WTX_WINDOW_NS / CLK_PERIOD_NS;
   localparam int RSP_FIFO_DEPTH = 32;
   localparam int RSP_FIFO_WIDTH = 9;
   typedef enum logic [1:0] {FILE_NONE, FILE_SYS, FILE_NDEF} tfa_file_type;
endpackage

/* src/tfa_byte_fifo.sv */
// Response FIFO: flop array with wrap-bit pointers.
// Assumes a single clock; the reader may stall as long as it likes.
`timescale 1ns/100ps
module tfa_byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wrPtr_r;
   logic [AW:0] rdPtr_r;
   logic full;
   logic empty;

   assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
   assign empty = (wrPtr_r == rdPtr_r);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem_r[rdPtr_r[AW-1:0]];

   always_ff @(posedge mclk) begin
      if (inValid && !full) begin
         mem_r[wrPtr_r[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
      end else begin
         if (inValid && !full) begin
            wrPtr_r <= wrPtr_r + 1'b1;
         end
         if (outReady && !empty) begin
            rdPtr_r <= rdPtr_r + 1'b1;
         end
      end
   end
endmodule

/* src/tfa_pwd_match.sv */
// Byte-wise comparison of a received password against a stored one.
// Purely combinational; the caller registers the verdict.
`timescale 1ns/100ps
module tfa_pwd_match #(
   parameter int BYTES = 16
) (
   input wire logic [BYTES*8-1:0] rxPwd,
   input wire logic [BYTES*8-1:0] refPwd,
   output logic match
);
   logic [BYTES-1:0] byteEq;

   // Every byte is judged; no early exit leaks which byte differed
   for (genvar i = 0; i < BYTES; i++) begin : g_byte
      assign byteEq[i] = (rxPwd[i*8 +: 8] == refPwd[i*8 +: 8]);
   end
   assign match = &byteEq;
endmodule

/* testbench/tfa_mem_model.sv */
// File memory seen from the engine's memory port, answering late or soon.
// Assumes one access at a time, held by the engine until acknowledged.
`timescale 1ns/100ps
module tfa_mem_model (
   input wire logic mclk,
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [15:0] memAddr,
   input wire logic [7:0] memWdata,
   input wire logic failWr,
   input wire logic slowMem,
   output logic [7:0] memRdata = 8'h00,
   output logic memAck = 1'b0,
   output logic memFail = 1'b0
);
   logic [7:0] mem [0:255];
   int w = 0;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
   // Read data flips between answers so a stale sample is never a lucky match
   always @(posedge mclk) begin
      memAck <= 1'b0;
      memFail <= 1'b0;
      memRdata <= ~memRdata;
      w <= 0;
      if (memReq === 1'b1 && !memAck) begin
         w <= w + 1;
         if (w >= (slowMem ? 12 : 1)) begin
            memAck <= 1'b1;
            memFail <= memWe & failWr;
            memRdata <= mem[memAddr[7:0]];
            if (memWe && !failWr) mem[memAddr[7:0]] <= memWdata;
            w <= 0;
         end
      end
   end
endmodule

/* testbench/tfa_apdu_engine_tb.sv */
// Frames go in byte by byte, response bytes are checked against expected queues.
// Assumes the memory model behind the engine and a 100 MHz clock.
`timescale 1ns/100ps
module tfa_apdu_engine_tb;
   import tfa_pkg::*;
   typedef logic [7:0] tfa_bytes_type[$];
   logic mclk = 0, rst = 1, sessionStart = 0, cmdValid = 0, cmdLast = 0, rspReady = 0;
   logic failWr = 0, slowMem = 0, sysFilePresent = 0, ndefFilePresent = 1;
   logic [7:0] cmdData = 0, ndefReadRight = ACC_PWD, ndefWriteRight = ACC_OPEN, rspData, memRdata, memWdata;
   logic [15:0] sysFileLen = 16'h0010, ndefFileLen = 16'h0040, memAddr;
   logic [PWD_BITS-1:0] readPassword = 0, writePassword = 0;
   logic cmdReady, rspValid, rspLast, memReq, memWe, memAck, memFail, wtxReq;
   tfa_file_type memFile;
   logic [1:0] retriesLeft;
   int fails = 0, n_checks = 0, nWtx = 0;
   tfa_bytes_type c, e;
   logic [7:0] img [256];
   always #5 mclk = ~mclk;
   always @(negedge mclk) if (wtxReq === 1'b1) nWtx++;
   tfa_apdu_engine #(.FIFO_DEPTH(RSP_FIFO_DEPTH), .WTX_LIMIT(8)) dut_u (.*);
   tfa_mem_model mem_u (.*);
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic hd(input logic [7:0] ins, p1, p2, p3);
      c = '{CLA_ISO, ins, p1, p2, p3};
   endtask
   task automatic go(input logic [15:0] sw, input string name);
      logic [7:0] x;
      e.push_back(sw[15:8]);
      e.push_back(sw[7:0]);
      foreach (c[i]) begin
         @(negedge mclk);
         cmdValid = 1;
         cmdData = c[i];
         cmdLast = (i == c.size() - 1);
         while (cmdReady !== 1'b1) @(negedge mclk);
      end
      // Consumer stalls at random so the response FIFO has to hold bytes
      for (int t = 0; t < 600 && e.size() > 0; t++) begin
         @(negedge mclk);
         cmdValid = 0;
         rspReady = 1'($urandom);
         if (rspValid === 1'b1 && rspReady) begin
            x = e.pop_front();
            chk({rspLast, rspData}, {e.size() == 0, x});
         end
      end
      if (e.size() > 0) chk(9'h100, 9'h000);
      e.delete();
      $display("done %s", name);
   endtask
   task automatic sel(input logic [15:0] fid, input logic [15:0] sw);
      hd(INS_SELECT, SEL_P1, SEL_P2, SEL_LC);
      c.push_back(fid[15:8]);
      c.push_back(fid[7:0]);
      go(sw, "select");
   endtask
   task automatic rd(input logic [15:0] off, input int n, input logic [15:0] sw);
      hd(INS_READ, off[15:8], off[7:0], 8'(n));
      if (sw == SW_OK) for (int i = 0; i < n; i++) e.push_back(img[8'(off + i)]);
      go(sw, "read");
   endtask
   task automatic upd(input logic [15:0] off, input int n, input logic [15:0] sw);
      hd(INS_UPDATE, off[15:8], off[7:0], 8'(n));
      for (int i = 0; i < n; i++) begin
         c.push_back(8'($urandom));
         if (sw == SW_OK) img[8'(off + i)] = c[HDR_BYTES + i];
      end
      go(sw, "update");
   endtask
   task automatic vfy(input logic [15:0] ps, input int n, input logic [7:0] flip, input logic [15:0] sw);
      hd(INS_VERIFY, ps[15:8], ps[7:0], 8'(n));
      for (int i = 0; i < n; i++) c.push_back(readPassword[127 - 8 * i -: 8] ^ (i == n - 1 ? flip : 8'h00));
      go(sw, "verify");
   endtask
   initial begin
      #300000;
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out;
   end
   initial begin
      void'($urandom(32'h8D75B39F));
      foreach (img[i]) img[i] = 8'(i) ^ 8'h5A;
      readPassword = {$urandom, $urandom, $urandom, $urandom};
      repeat (10) @(negedge mclk);
      rst = 0;
      sel(FID_SYSTEM, SW_NOT_FOUND);
      rd(16'h0000, 1, SW_NOT_FOUND);
      upd(16'h0000, 1, SW_NOT_FOUND);
      sysFilePresent = 1;
      sel(FID_SYSTEM, SW_OK);
      rd(16'h0002, 4, SW_OK);
      rd(16'h000D, 3, SW_OK);
      rd(16'h000E, 3, SW_WRONG_LEN);
      upd(16'h0000, 1, SW_SECURITY);
      vfy(PWD_SEL_READ, 0, 8'h00, SW_REF_UNUSABLE);
      sel(FID_NDEF, SW_OK);
      rd(16'h0000, 1, SW_SECURITY);
      vfy(PWD_SEL_READ, 0, 8'h00, SW_PWD_REQ);
      vfy(16'h0003, 0, 8'h00, SW_BAD_P1P2);
      vfy(PWD_SEL_READ, 5, 8'h00, SW_BAD_DATA);
      vfy(PWD_SEL_READ, 16, 8'h01, {SW_PWD_BAD_HI, 4'h2});
      vfy(PWD_SEL_READ, 16, 8'h80, {SW_PWD_BAD_HI, 4'h1});
      chk({7'h00, retriesLeft}, 9'h001);
      vfy(PWD_SEL_READ, 16, 8'h00, SW_OK);
      rd(16'h003E, 2, SW_OK);
      slowMem = 1;
      upd(16'h003C, 2, SW_OK);
      chk(9'(nWtx > 0), 9'h001);
      slowMem = 0;
      rd(16'h003C, 2, SW_OK);
      chk({7'h00, memFile}, {7'h00, FILE_NDEF});
      upd(16'h0000, 0, SW_WRONG_LEN);
      failWr = 1;
      upd(16'h0000, 1, SW_UPD_FAIL);
      failWr = 0;
      ndefWriteRight = ACC_LOCK_WR;
      vfy(PWD_SEL_WRITE, 0, 8'h00, SW_REF_UNUSABLE);
      @(negedge mclk) sessionStart = 1;
      @(negedge mclk) sessionStart = 0;
      chk({7'h00, retriesLeft}, 9'h003);
      sel(FID_NDEF, SW_OK);
      rd(16'h0000, 1, SW_SECURITY);
      close_out;
   end
endmodule
